// [bench/fault_host.sv]
// Host model that answers reported faults with clear requests
`timescale 1ns/1ns
`include "fault_mon_map.svh"
module fault_host (
	// Clock and command from the bench
	input wire logic clk,
	input wire logic clear_go,
	// Input data from the module
	input wire logic [`FLT_WIDTH-1:0] fault_report,
	// Output data to the module
	output logic host_clear_req
);
	// Clear asked only while a fault is reported
	initial host_clear_req = 1'b0;
	always @(negedge clk) begin
		host_clear_req <= clear_go && (|fault_report);
	end
endmodule // fault_host

// [bench/fault_mon_asserts.sv]
// Port checks for the fault status monitor
`timescale 1ns/1ns
`include "fault_mon_map.svh"
module fault_mon_asserts (
	// Clock and inputs
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic init_done,
	input wire logic short_detect,
	input wire logic motor_current_en,
	input wire logic short_needs_current,
	input wire logic [7:0] heatsink_temp_c,
	input wire logic flash_write_ok,
	input wire logic flash_write_fail,
	input wire logic comm_fail_internal,
	input wire logic comm_fail_stack,
	input wire logic host_clear_req,
	input wire logic output_fault_mode,
	input wire logic [`ADDR_SW_WIDTH-1:0] addr_switch,
	input wire logic has_net_if,
	// Outputs
	input wire logic [`FLT_WIDTH-1:0] fault_report,
	input wire logic any_fault,
	input wire logic discrete_out,
	input wire logic [`ADDR_WIDTH-1:0] stack_addr,
	input wire logic net_if_enable,
	input wire logic host_cmd_accept,
	input wire logic cmd_locked,
	input wire logic led_green_on,
	input wire logic led_red_on
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Short seen while sensing allowed
	sequence s_short;
		ce && short_detect && (motor_current_en || !short_needs_current);
	endsequence
	// Clear asked with the short gone two edges
	sequence s_calm;
		ce && host_clear_req && !short_detect ##1 ce && !short_detect;
	endsequence
	a_init_fault: assert property (ce && !init_done |=> fault_report[0])
		else $error("init fault missing");
	a_short_fault: assert property (s_short |=> fault_report[1])
		else $error("short fault missing");
	a_temp_fault: assert property (ce && heatsink_temp_c > 8'h5a |=> fault_report[2])
		else $error("temp fault missing");
	a_fault_out: assert property ($past(rst_n) && $past(output_fault_mode) |-> discrete_out == !any_fault)
		else $error("fault output wrong");
	a_clear_latch: assert property (s_calm |=> !fault_report[1])
		else $error("short not cleared");
	a_addr_one: assert property (ce && $onehot(addr_switch) |=> $past(addr_switch) == (5'h01 << (stack_addr - 3'h1)))
		else $error("stack address wrong");
	a_addr_zero: assert property (ce && addr_switch == 5'h00 |=> stack_addr == 3'h0 && net_if_enable == $past(has_net_if))
		else $error("address zero wrong");
	a_cmd_lock: assert property (ce && flash_write_ok |=> (cmd_locked && !host_cmd_accept) [*8])
		else $error("commands not locked");
	// Sticky flag lands one edge late, report one more
	a_comm_alt: assert property (ce && comm_fail_stack |=> ##1 fault_report[4] ##1 (led_red_on ^ led_green_on) [*8])
		else $error("comm pattern wrong");
	// No sticky pattern pending: red shows one edge later
	a_led_red: assert property (ce && heatsink_temp_c > 8'h5a && !cmd_locked && !$past(flash_write_fail) && !$past(comm_fail_internal) && !$past(comm_fail_stack) && fault_report[4:3] == 2'h0 |=> led_red_on && !led_green_on)
		else $error("led not red");
endmodule // fault_mon_asserts

// [bench/module_fault_status_monitor_bench.sv]
// Self-checking bench for the fault status monitor
`timescale 1ns/1ns
`include "fault_mon_map.svh"
module module_fault_status_monitor_bench;
	// Stimulus and observed signals
	logic clk, rst_n, init_done, short_detect, motor_current_en;
	logic short_needs_current, flash_write_ok, flash_write_fail, clear_go;
	logic comm_fail_internal, comm_fail_stack, host_clear_req, addr_error;
	logic output_fault_mode, gp_output_value, host_cmd_valid, has_net_if;
	logic any_fault, discrete_out, net_if_enable, host_cmd_accept;
	logic cmd_locked, led_green_on, led_red_on, ce;
	logic [7:0] heatsink_temp_c;
	logic [`ADDR_SW_WIDTH-1:0] addr_switch;
	logic [`FLT_WIDTH-1:0] fault_report;
	logic [`ADDR_WIDTH-1:0] stack_addr;
	int n_errors = 0;
	int checks_done = 0;
	module_fault_status_monitor #(.blink_cycles(4)) u_dut (.clk, .rst_n,
		.ce, .init_done, .short_detect, .motor_current_en,
		.short_needs_current, .heatsink_temp_c, .flash_write_ok,
		.flash_write_fail, .comm_fail_internal, .comm_fail_stack,
		.host_clear_req, .output_fault_mode, .gp_output_value,
		.host_cmd_valid, .addr_switch, .has_net_if, .fault_report,
		.any_fault, .discrete_out, .stack_addr, .addr_error, .net_if_enable,
		.host_cmd_accept, .cmd_locked, .led_green_on, .led_red_on);
	fault_host u_host (.clk, .clear_go, .fault_report, .host_clear_req);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic do_reset();
		rst_n <= 1'b0;
		ce <= 1'b1;
		{init_done, short_detect, motor_current_en, clear_go} <= 4'h0;
		{short_needs_current, host_cmd_valid, flash_write_ok} <= 3'h0;
		{flash_write_fail, comm_fail_internal, comm_fail_stack} <= 3'h0;
		{output_fault_mode, has_net_if, gp_output_value} <= 3'h6;
		heatsink_temp_c <= 8'h20;
		addr_switch <= 5'h00;
		cyc(12);
		rst_n <= 1'b1;
	endtask
	task automatic do_clear();
		clear_go <= 1'b1;
		cyc(4);
		clear_go <= 1'b0;
		cyc(3);
	endtask
	task automatic t_init();
		cyc(2);
		chk("reset fault", 8'h01, 8'(fault_report));
		chk("fault out", 8'h00, 8'(discrete_out));
		output_fault_mode <= 1'b0;
		for (int v = 0; v < 2; v++) begin
			gp_output_value <= v[0];
			cyc(1);
			chk("gp out", 8'(v), 8'(discrete_out));
		end
		{output_fault_mode, init_done} <= 2'h3;
		cyc(3);
		chk("reset held", 8'h01, 8'(fault_report));
		do_clear();
		chk("cleared", 8'h00, 8'(fault_report));
		chk("fault out", 8'h01, 8'(discrete_out));
		chk("led", 8'h01, 8'({led_red_on, led_green_on}));
	endtask
	task automatic t_short();
		{short_needs_current, short_detect} <= 2'h3;
		cyc(2);
		chk("short gated", 8'h00, 8'(fault_report));
		motor_current_en <= 1'b1;
		cyc(2);
		chk("short", 8'h02, 8'(fault_report));
		chk("led red", 8'h02, 8'({led_red_on, led_green_on}));
		short_detect <= 1'b0;
		cyc(3);
		chk("short held", 8'h02, 8'(fault_report));
		do_clear();
		chk("short clear", 8'h00, 8'(fault_report));
		heatsink_temp_c <= 8'h5a;
		cyc(2);
		chk("temp 90", 8'h00, 8'(fault_report));
		heatsink_temp_c <= 8'h5b;
		cyc(1);
		chk("temp 91", 8'h04, 8'(fault_report));
	endtask
	task automatic t_addr();
		for (int i = -1; i < 5; i++) begin
			addr_switch <= (i < 0) ? 5'h00 : 5'(5'h01 << i);
			cyc(1);
			chk("stack addr", 8'(i + 1), 8'(stack_addr));
			chk("net if", 8'(i < 0), 8'(net_if_enable));
		end
		addr_switch <= 5'h03;
		cyc(1);
		chk("bad addr", 8'h17, 8'({addr_error, net_if_enable, stack_addr}));
		// Enable low freezes the decoded address
		ce <= 1'b0;
		addr_switch <= 5'h00;
		cyc(2);
		chk("frozen", 8'h17, 8'({addr_error, net_if_enable, stack_addr}));
		ce <= 1'b1;
	endtask
	task automatic t_sticky();
		logic [1:0] seen;
		logic both;
		for (int k = 0; k < 4; k++) begin
			do_reset();
			seen = 2'h0;
			both = 1'b0;
			{init_done, host_cmd_valid} <= 2'h3;
			heatsink_temp_c <= 8'h5b;
			{flash_write_fail, comm_fail_internal, comm_fail_stack,
				flash_write_ok} <= 4'(4'h8 >> k);
			cyc(1);
			{flash_write_fail, comm_fail_internal, comm_fail_stack,
				flash_write_ok} <= 4'h0;
			repeat (16) begin
				cyc(1);
				seen = seen | {led_red_on, led_green_on};
				both = both | (led_red_on & led_green_on);
			end
			chk("led seen", (k == 0) ? 8'h02 : (k == 3) ? 8'h01 : 8'h03,
				8'({both, seen}));
			do_clear();
			chk("sticky", (k == 0) ? 8'h0c : (k == 3) ? 8'h04 : 8'h14,
				8'(fault_report));
			chk("cmd accept", 8'(k != 3), 8'(host_cmd_accept));
		end
	endtask
	task automatic summarize();
		$display("Checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		do_reset();
		t_init();
		t_short();
		t_addr();
		t_sticky();
		summarize();
	end
	initial begin
		#200000;
		n_errors++;
		summarize();
	end
endmodule // module_fault_status_monitor_bench
bind module_fault_status_monitor fault_mon_asserts u_chk (.clk, .rst_n,
	.ce, .init_done, .short_detect, .motor_current_en, .short_needs_current,
	.heatsink_temp_c, .flash_write_ok, .flash_write_fail, .comm_fail_internal,
	.comm_fail_stack, .host_clear_req,
	.output_fault_mode, .addr_switch, .has_net_if, .fault_report, .any_fault,
	.discrete_out, .stack_addr, .net_if_enable, .host_cmd_accept,
	.cmd_locked, .led_green_on, .led_red_on);

// [design/fault_mon_map.svh]
// Offsets, field positions and timing counts of the fault status monitor
`ifndef FAULT_MON_MAP_SVH
`define FAULT_MON_MAP_SVH

// ****************************************************************
// Fault field positions in the report word
// ****************************************************************
`define FLT_BIT_RESET 0
`define FLT_BIT_SHORT 1
`define FLT_BIT_TEMP 2
`define FLT_BIT_FLASH 3
`define FLT_BIT_COMM 4
`define FLT_WIDTH 5

// ****************************************************************
// Stack addressing
// ****************************************************************
`define STACK_MAX 6
`define ADDR_SW_WIDTH 5
`define ADDR_WIDTH 3
`define ADDR_INVALID 3'h7

// ****************************************************************
// Thermal threshold and timing
// ****************************************************************
`define TEMP_LIMIT_C 8'h5a
`define CLK_HZ 25000000
`define BLINK_MS 250
`define BLINK_CYCLES ((`CLK_HZ / 1000) * `BLINK_MS)
`define BLINK_CNT_WIDTH 23

`endif

// [design/fault_mon_pkg.sv]
// Types shared by the fault status monitor
package fault_mon_pkg;

	// Indicator display pattern
	typedef enum logic [2:0] {
		led_off_type_v,
		led_green,
		led_red,
		led_blink_green,
		led_blink_red,
		led_alternate
	} led_mode_type;

endpackage

// [design/led_driver.sv]
// Bi-colour indicator driver with blink timebase
`timescale 1ns/1ns
`include "fault_mon_map.svh"

module led_driver #(
	parameter int blink_cycles = `BLINK_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Pattern select
	input wire fault_mon_pkg::led_mode_type mode,
	// Indicator drive
	output logic led_green_on,
	output logic led_red_on
);

	// Blink timebase counter
	logic [`BLINK_CNT_WIDTH-1:0] cnt_ff;
	// Blink phase
	logic phase_ff;
	// Terminal count
	logic wrap;

	assign wrap = (cnt_ff == `BLINK_CNT_WIDTH'(blink_cycles - 1));

	// ****************************************************************
	// Timebase
	// ****************************************************************
	// Free running phase toggle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
			phase_ff <= 1'b0;
		end else if (ce) begin
			if (wrap) begin
				cnt_ff <= '0;
				phase_ff <= ~phase_ff;
			end else begin
				cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end

	// ****************************************************************
	// Colour outputs
	// ****************************************************************
	// Registered colour per pattern
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			led_green_on <= 1'b0;
			led_red_on <= 1'b0;
		end else if (ce) begin
			unique case (mode)
				fault_mon_pkg::led_off_type_v: begin
					led_green_on <= 1'b0;
					led_red_on <= 1'b0;
				end
				fault_mon_pkg::led_green: begin
					led_green_on <= 1'b1;
					led_red_on <= 1'b0;
				end
				fault_mon_pkg::led_red: begin
					led_green_on <= 1'b0;
					led_red_on <= 1'b1;
				end
				fault_mon_pkg::led_blink_green: begin
					led_green_on <= phase_ff;
					led_red_on <= 1'b0;
				end
				fault_mon_pkg::led_blink_red: begin
					led_green_on <= 1'b0;
					led_red_on <= phase_ff;
				end
				fault_mon_pkg::led_alternate: begin
					led_green_on <= phase_ff;
					led_red_on <= ~phase_ff;
				end
				default: begin
					led_green_on <= 1'b0;
					led_red_on <= 1'b0;
				end
			endcase
		end
	end

endmodule // led_driver

// [design/module_fault_status_monitor.sv]
// Fault gathering, fault output, stack address and status indicator
`timescale 1ns/1ns
`include "fault_mon_map.svh"

module module_fault_status_monitor #(
	parameter int blink_cycles = `BLINK_CYCLES
) (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Driver conditions
	input wire logic init_done,
	input wire logic short_detect,
	input wire logic motor_current_en,
	input wire logic short_needs_current,
	input wire logic [7:0] heatsink_temp_c,
	// Flash write results
	input wire logic flash_write_ok,
	input wire logic flash_write_fail,
	// Communication failures
	input wire logic comm_fail_internal,
	input wire logic comm_fail_stack,
	// Host output data
	input wire logic host_clear_req,
	input wire logic output_fault_mode,
	input wire logic gp_output_value,
	input wire logic host_cmd_valid,
	// Stack address switches
	input wire logic [`ADDR_SW_WIDTH-1:0] addr_switch,
	input wire logic has_net_if,
	// Host input data
	output logic [`FLT_WIDTH-1:0] fault_report,
	output logic any_fault,
	// Discrete output
	output logic discrete_out,
	// Stack state
	output logic [`ADDR_WIDTH-1:0] stack_addr,
	output logic addr_error,
	output logic net_if_enable,
	// Command gate
	output logic host_cmd_accept,
	output logic cmd_locked,
	// Indicator
	output logic led_green_on,
	output logic led_red_on
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	// Latched fault flags
	logic [`FLT_WIDTH-1:0] fault_ff;
	// Live fault conditions
	logic [`FLT_WIDTH-1:0] live;
	// Sticky flash success lock
	logic flash_ok_ff;
	// Sticky flash failure
	logic flash_fail_ff;
	// Sticky comm failure
	logic comm_fail_ff;
	// Short condition after qualification
	logic short_live;
	// Over temperature condition
	logic temp_live;
	// Decoded address and validity
	logic [`ADDR_WIDTH-1:0] nxt_addr;
	logic nxt_addr_bad;
	// Indicator pattern
	fault_mon_pkg::led_mode_type led_mode;

	// ****************************************************************
	// Fault conditions
	// ****************************************************************
	// Some variants sense shorts only with current on
	assign short_live = short_detect &
		(motor_current_en | ~short_needs_current);
	// Strictly above the threshold
	assign temp_live = (heatsink_temp_c > `TEMP_LIMIT_C);

	// Live condition vector
	always_comb begin
		live = '0;
		live[`FLT_BIT_RESET] = ~init_done;
		live[`FLT_BIT_SHORT] = short_live;
		live[`FLT_BIT_TEMP] = temp_live;
		live[`FLT_BIT_FLASH] = flash_fail_ff;
		live[`FLT_BIT_COMM] = comm_fail_ff;
	end

	// ****************************************************************
	// Fault latches
	// ****************************************************************
	// Set wins over clear; clear only once condition gone
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_ff <= `FLT_WIDTH'(1 << `FLT_BIT_RESET);
		end else if (ce) begin
			if (host_clear_req) begin
				fault_ff <= live;
			end else begin
				fault_ff <= fault_ff | live;
			end
		end
	end

	// ****************************************************************
	// Power-cycle only conditions
	// ****************************************************************
	// Flash result and comm failure hold until reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flash_ok_ff <= 1'b0;
			flash_fail_ff <= 1'b0;
			comm_fail_ff <= 1'b0;
		end else if (ce) begin
			if (flash_write_ok) begin
				flash_ok_ff <= 1'b1;
			end
			if (flash_write_fail) begin
				flash_fail_ff <= 1'b1;
			end
			if (comm_fail_internal | comm_fail_stack) begin
				comm_fail_ff <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Host report and discrete output
	// ****************************************************************
	// Report word and output pin from flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_report <= '0;
			any_fault <= 1'b0;
			discrete_out <= 1'b0;
		end else if (ce) begin
			fault_report <= fault_ff | live;
			any_fault <= |(fault_ff | live);
			if (output_fault_mode) begin
				discrete_out <= ~|(fault_ff | live);
			end else begin
				discrete_out <= gp_output_value;
			end
		end
	end

	// ****************************************************************
	// Stack address decode
	// ****************************************************************
	// All off is zero, one switch is its position
	always_comb begin
		nxt_addr = '0;
		nxt_addr_bad = 1'b0;
		unique case (addr_switch)
			5'h00: nxt_addr = 3'h0;
			5'h01: nxt_addr = 3'h1;
			5'h02: nxt_addr = 3'h2;
			5'h04: nxt_addr = 3'h3;
			5'h08: nxt_addr = 3'h4;
			5'h10: nxt_addr = 3'h5;
			default: begin
				nxt_addr = `ADDR_INVALID;
				nxt_addr_bad = 1'b1;
			end
		endcase
	end

	// Registered address and interface enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stack_addr <= '0;
			addr_error <= 1'b0;
			net_if_enable <= 1'b0;
		end else if (ce) begin
			stack_addr <= nxt_addr;
			addr_error <= nxt_addr_bad;
			net_if_enable <= has_net_if & (nxt_addr == 3'h0);
		end
	end

	// ****************************************************************
	// Command gate
	// ****************************************************************
	// Commands refused after successful flash write until power cycle
	assign cmd_locked = flash_ok_ff;
	assign host_cmd_accept = host_cmd_valid & ~flash_ok_ff;

	// ****************************************************************
	// Indicator priority
	// ****************************************************************
	// Comm and flash over red over green
	always_comb begin
		if (comm_fail_ff) begin
			led_mode = fault_mon_pkg::led_alternate;
		end else if (flash_fail_ff) begin
			led_mode = fault_mon_pkg::led_blink_red;
		end else if (flash_ok_ff) begin
			led_mode = fault_mon_pkg::led_blink_green;
		end else if (fault_ff[`FLT_BIT_SHORT] | fault_ff[`FLT_BIT_TEMP]
			| short_live | temp_live) begin
			led_mode = fault_mon_pkg::led_red;
		end else if (init_done) begin
			led_mode = fault_mon_pkg::led_green;
		end else begin
			led_mode = fault_mon_pkg::led_off_type_v;
		end
	end

	// Indicator pattern generator
	led_driver #(
		.blink_cycles(blink_cycles)
	) u_led (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.mode(led_mode),
		.led_green_on(led_green_on),
		.led_red_on(led_red_on)
	);

endmodule // module_fault_status_monitor
